// ==== hw/dtsl_pkg.sv ====
// package: register map, fields and types of the debug trigger and status logic
package dtsl_pkg;
    localparam int ADDR_W = 4;
    // register offsets (own choice, no offsets printed)
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_TRIG = 4'h1;
    localparam logic [3:0] OFF_STAT = 4'h2;
    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_ARM_BIT = 6;
    localparam int CTRL_TAG_BIT = 5;
    localparam int CTRL_BRK_BIT = 4;
    // trigger register fields
    localparam int TRIG_TAGQ_BIT = 7;
    localparam int TRIG_BEGIN_BIT = 6;
    localparam logic [7:0] TRIG_WMASK = 8'hCF;
    // status register fields
    localparam int STAT_AHIT_BIT = 7;
    localparam int STAT_BHIT_BIT = 6;
    localparam int STAT_CAPTURE_ACTIVE_FLAG_BIT = 5;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] TRIG_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        TM_A_ONLY = 4'h0,
        TM_A_OR_B = 4'h1,
        TM_A_THEN_B = 4'h2,
        TM_EVT_B = 4'h3,
        TM_A_THEN_EVT_B = 4'h4,
        TM_A_AND_BDATA = 4'h5,
        TM_A_NOT_BDATA = 4'h6,
        TM_INSIDE = 4'h7,
        TM_OUTSIDE = 4'h8
    } dtsl_mode_t;

    // run states, gray along idle -> wait -> store and wait -> idle; store -> idle flips both bits
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_WAIT = 2'b01,
        RS_STORE = 2'b11
    } dtsl_run_t;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dtsl_bus_t;

    // comparator and tracking inputs
    typedef struct packed {
        logic match_a;
        logic match_b;
        logic data_b;
        logic addr_ge_a;
        logic addr_le_b;
        logic access;
        logic exec_a;
        logic exec_b;
    } dtsl_cmp_t;
endpackage : dtsl_pkg

// ==== hw/dtsl_top.sv ====
// top: trigger, control and status registers with debug run sequencing
module dtsl_top
    import dtsl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // device state
    input wire logic SECURE,
    // comparator and opcode tracking events
    input wire dtsl_cmp_t CMP,
    // capture fifo side
    input wire logic FIFO_STORE,
    input wire logic FIFO_READ,
    output logic FIFO_WR_EN,
    output logic FIFO_CLEAR,
    // cpu break
    output logic BRK_REQ,
    output logic BRK_TAG,
    // run status
    output logic ARMED
);
    typedef struct packed {
        logic en;
        logic arm;
        logic tag;
        logic brk;
        logic [3:0] rwbits;
        logic [7:0] trig;
        logic a_hit;
        logic b_hit;
        logic a_seen;
        logic [3:0] cnt;
        dtsl_run_t run;
        logic brk_req;
        logic [7:0] rdata;
    } dtsl_state_t;

    dtsl_state_t st_reg;
    dtsl_state_t st_next;
    dtsl_bus_t bus;
    logic trig_ev;
    logic evt_only;
    logic hit_a;
    logic hit_b;
    logic begin_trace;
    logic storing;
    logic store_ok;
    logic full_now;
    logic run_end;
    logic [7:0] stat_val;
    logic [7:0] ctrl_val;

    dtsl_trig_decode u_dec (
        .mode(st_reg.trig[3:0]),
        .tag_qual(st_reg.trig[TRIG_TAGQ_BIT]),
        .a_seen(st_reg.a_seen),
        .cmp(CMP),
        .trig(trig_ev),
        .event_only(evt_only),
        .hit_a(hit_a),
        .hit_b(hit_b)
    );

    always_comb begin
        bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
        begin_trace = st_reg.trig[TRIG_BEGIN_BIT] || evt_only;
        storing = (st_reg.run == RS_STORE) || (st_reg.run == RS_WAIT && !begin_trace);
        store_ok = storing && FIFO_STORE;
        full_now = store_ok && (st_reg.cnt == 4'(DEPTH - 1)) && begin_trace
            && (st_reg.run == RS_STORE);
        ctrl_val = {st_reg.en, st_reg.arm, st_reg.tag, st_reg.brk, st_reg.rwbits};
        stat_val = {st_reg.a_hit, st_reg.b_hit, st_reg.en && st_reg.arm, 1'b0, st_reg.cnt};
    end

    always_comb begin
        st_next = st_reg;
        st_next.brk_req = 1'b0;
        run_end = 1'b0;
        // read data in the cycle after the strobe
        st_next.rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == OFF_CTRL) begin
                st_next.rdata = ctrl_val;
            end else if (bus.addr == OFF_TRIG) begin
                // always readable, bits 4 and 5 zero
                st_next.rdata = st_reg.trig & TRIG_WMASK;
            end else if (bus.addr == OFF_STAT) begin
                st_next.rdata = stat_val;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
        // run sequencing
        case (st_reg.run)
            RS_IDLE: ;
            RS_WAIT: begin
                if (hit_a) begin
                    st_next.a_hit = 1'b1;
                    st_next.a_seen = 1'b1;
                end
                if (hit_b) st_next.b_hit = 1'b1;
                if (store_ok && st_reg.cnt != 4'(DEPTH)) st_next.cnt = st_reg.cnt + 4'h1;
                if (trig_ev) begin
                    // begin trace starts storing, end trace stops
                    if (begin_trace) begin
                        st_next.run = RS_STORE;
                    end else begin
                        run_end = 1'b1;
                        st_next.brk_req = st_reg.brk;
                    end
                end
            end
            RS_STORE: begin
                if (hit_a) st_next.a_hit = 1'b1;
                if (hit_b) st_next.b_hit = 1'b1;
                if (store_ok) st_next.cnt = st_reg.cnt + 4'h1;
                // full fifo ends a begin trace
                if (full_now) begin
                    run_end = 1'b1;
                    st_next.brk_req = st_reg.brk;
                end
            end
            default: st_next.run = RS_IDLE;
        endcase
        // capture bit clears itself at run end
        if (run_end) begin
            st_next.arm = 1'b0;
            st_next.run = RS_IDLE;
        end
        // fifo reads leave the count alone
        if (FIFO_READ) st_next.cnt = st_next.cnt;
        if (bus.wr) begin
            if (bus.addr == OFF_CTRL) begin
                st_next.en = bus.wdata[CTRL_EN_BIT] && !SECURE;
                st_next.tag = bus.wdata[CTRL_TAG_BIT];
                st_next.brk = bus.wdata[CTRL_BRK_BIT];
                st_next.rwbits = bus.wdata[3:0];
                if (!bus.wdata[CTRL_ARM_BIT] || !st_next.en) begin
                    st_next.arm = 1'b0;
                    st_next.run = RS_IDLE;
                end else begin
                    // write of one starts a run
                    st_next.arm = 1'b1;
                    st_next.run = RS_WAIT;
                    st_next.a_hit = 1'b0;
                    st_next.b_hit = 1'b0;
                    st_next.a_seen = 1'b0;
                    st_next.cnt = CNT_RST;
                end
            end else if (bus.addr == OFF_TRIG) begin
                if (!st_reg.arm) st_next.trig = bus.wdata & TRIG_WMASK;
            end else begin
                // status and unmapped writes have no effect
                st_next.trig = st_next.trig;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_reg <= '{en: CTRL_RST[CTRL_EN_BIT], arm: CTRL_RST[CTRL_ARM_BIT],
                tag: CTRL_RST[CTRL_TAG_BIT], brk: CTRL_RST[CTRL_BRK_BIT], rwbits: CTRL_RST[3:0],
                trig: TRIG_RST, a_hit: 1'b0, b_hit: 1'b0, a_seen: 1'b0, cnt: CNT_RST,
                run: RS_IDLE, brk_req: 1'b0, rdata: 8'h00};
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA = st_reg.rdata;
    assign FIFO_WR_EN = store_ok;
    assign FIFO_CLEAR = bus.wr && bus.addr == OFF_CTRL && st_next.run == RS_WAIT;
    assign BRK_REQ = st_reg.brk_req;
    assign BRK_TAG = st_reg.tag;
    assign ARMED = st_reg.arm;
endmodule // dtsl_top

// ==== hw/dtsl_trig_decode.sv ====
// trigger mode decoder: combines comparator events into one trigger pulse
module dtsl_trig_decode
    import dtsl_pkg::*;
(
    // mode
    input wire logic [3:0] mode,
    input wire logic tag_qual,
    input wire logic a_seen,
    // comparator events
    input wire dtsl_cmp_t cmp,
    // results
    output logic trig,
    output logic event_only,
    output logic hit_a,
    output logic hit_b
);
    logic ev_a;
    logic ev_b;
    logic in_range;

    always_comb begin
        ev_a = tag_qual ? cmp.exec_a : cmp.match_a;
        ev_b = tag_qual ? cmp.exec_b : cmp.match_b;
        in_range = cmp.addr_ge_a && cmp.addr_le_b;
        hit_a = ev_a;
        hit_b = ev_b;
    end

    always_comb begin
        trig = 1'b0;
        event_only = 1'b0;
        case (mode)
            TM_A_ONLY: trig = ev_a;
            TM_A_OR_B: trig = ev_a || ev_b;
            TM_A_THEN_B: trig = a_seen && ev_b;
            TM_EVT_B: begin
                trig = ev_b;
                event_only = 1'b1;
            end
            TM_A_THEN_EVT_B: begin
                trig = a_seen && ev_b;
                event_only = 1'b1;
            end
            TM_A_AND_BDATA: trig = ev_a && cmp.data_b;
            TM_A_NOT_BDATA: trig = ev_a && !cmp.data_b;
            TM_INSIDE: trig = cmp.access && in_range;
            TM_OUTSIDE: trig = cmp.access && !in_range;
            // codes 1001 to 1111 never trigger
            default: trig = 1'b0;
        endcase
    end
endmodule // dtsl_trig_decode

// ==== verif/debug_trigger_status_logic_test.sv ====
// testbench: registers, runs and trigger modes of the trigger and status logic
module debug_trigger_status_logic_test import dtsl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic SECURE = 1'b0;
    logic FIFO_STORE = 1'b0;
    dtsl_cmp_t CMP = '0;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA;
    logic WR, RD, FIFO_READ, FIFO_WR_EN, FIFO_CLEAR, BRK_REQ, BRK_TAG, ARMED;
    logic brk_seen = 1'b0;
    logic m_arm = 1'b0;
    int m_trig = 0;
    int n_fail = 0;
    int compares = 0;
    int n_wr = 0;
    dtsl_host host (.MCLK(MCLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .FIFO_READ(FIFO_READ));
    dtsl_top #(.DEPTH(FIFO_DEPTH)) dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SECURE(SECURE), .CMP(CMP), .FIFO_STORE(FIFO_STORE),
        .FIFO_READ(FIFO_READ), .FIFO_WR_EN(FIFO_WR_EN), .FIFO_CLEAR(FIFO_CLEAR),
        .BRK_REQ(BRK_REQ), .BRK_TAG(BRK_TAG), .ARMED(ARMED));
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        if (BRK_REQ === 1'b1) brk_seen <= 1'b1;
        if (FIFO_WR_EN === 1'b1) n_wr <= n_wr + 1;
    end
    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic pulse(input logic [7:0] c, input logic st);
        @(posedge MCLK);
        CMP <= dtsl_cmp_t'(c);
        FIFO_STORE <= st;
        @(posedge MCLK);
        CMP <= '0;
        FIFO_STORE <= 1'b0;
        #1;
    endtask
    task automatic set_trig(input logic [7:0] v);
        host.wr(OFF_TRIG, v);
        if (!m_arm) m_trig = v & TRIG_WMASK;
        chk_reg(OFF_TRIG, 8'(m_trig));
    endtask
    task automatic run_begin(input logic [7:0] tv, pre, ct, es);
        set_trig(tv);
        host.wr(OFF_CTRL, 8'hD0);
        m_arm = 1'b1;
        brk_seen = 1'b0;
        n_wr = 0;
        chk_reg(OFF_STAT, 8'h20);
        set_trig(8'h00);
        host.wr(OFF_STAT, 8'hFF);
        chk_reg(OFF_STAT, 8'h20);
        pulse(pre, 1'b1);
        pulse(ct, 1'b0);
        repeat (7) pulse(8'h00, 1'b1);
        chk({7'h00, ARMED}, 8'h01);
        pulse(8'h00, 1'b1);
        m_arm = 1'b0;
        repeat (2) @(posedge MCLK);
        chk({6'h00, ARMED, brk_seen}, 8'h01);
        chk(8'(n_wr), 8'h08);
        chk_reg(OFF_STAT, es);
        host.fifo_rd(3);
        chk_reg(OFF_STAT, es);
    endtask
    task automatic run_end(input logic [7:0] tv, cno, cyes, input logic fires);
        set_trig(tv);
        host.wr(OFF_CTRL, 8'hF0);
        m_arm = 1'b1;
        brk_seen = 1'b0;
        n_wr = 0;
        repeat (10) pulse(8'h00, 1'b1);
        pulse(cno, 1'b0);
        chk({6'h00, ARMED, BRK_TAG}, 8'h03);
        chk(8'(n_wr), 8'h0A);
        pulse(cyes, 1'b0);
        chk({7'h00, ARMED}, {7'h00, !fires});
        host.wr(OFF_CTRL, 8'h80);
        m_arm = 1'b0;
        chk({5'h00, ARMED, BRK_TAG, brk_seen}, {7'h00, fires});
    endtask
    initial begin
        repeat (20000) @(posedge MCLK);
        n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h80CE5D6E));
        repeat (3) @(posedge MCLK);
        SYS_RST <= 1'b0;
        chk_reg(OFF_CTRL, 8'h00);
        chk_reg(OFF_TRIG, 8'h00);
        chk_reg(OFF_STAT, 8'h00);
        repeat (4) set_trig(8'($urandom()));
        @(posedge MCLK) SECURE <= 1'b1;
        host.wr(OFF_CTRL, 8'hC0);
        chk_reg(OFF_CTRL, 8'h00);
        @(posedge MCLK) SECURE <= 1'b0;
        run_begin(8'h40, 8'h00, 8'h84, 8'h88);
        run_begin(8'h03, 8'h00, 8'h44, 8'h48);
        run_begin(8'h04, 8'h84, 8'h44, 8'hC8);
        run_end(8'h01, 8'h00, 8'h44, 1'b1);
        chk_reg(OFF_STAT, 8'h48);
        run_end(8'h02, 8'hC4, 8'h44, 1'b1);
        run_end(8'h05, 8'h84, 8'hA4, 1'b1);
        run_end(8'h06, 8'hA4, 8'h84, 1'b1);
        run_end(8'h80, 8'h84, 8'h86, 1'b1);
        run_end(8'h07, 8'h14, 8'h1C, 1'b1);
        run_end(8'h08, 8'h1C, 8'h0C, 1'b1);
        for (int m = 9; m < 16; m++) run_end(8'(m), 8'hFF, 8'hFF, 1'b0);
        // reset again in the middle of an armed run
        host.wr(OFF_CTRL, 8'hC0);
        @(posedge MCLK) SYS_RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        SYS_RST <= 1'b0;
        m_arm = 1'b0;
        chk({7'h00, ARMED}, 8'h00);
        chk_reg(OFF_CTRL, 8'h00);
        chk_reg(OFF_TRIG, 8'h00);
        chk_reg(OFF_STAT, 8'h00);
        report_and_stop();
    end
endmodule // debug_trigger_status_logic_test

// ==== verif/dtsl_host.sv ====
// partner: debug host driving the register port and fifo reads
module dtsl_host
    import dtsl_pkg::*;
(
    // clock
    input wire logic MCLK,
    // register port
    output logic [3:0] ADDR,
    output logic [7:0] WDATA,
    output logic WR,
    output logic RD,
    input wire logic [7:0] RDATA,
    // fifo read strobe
    output logic FIFO_READ
);
    timeunit 1ns;
    timeprecision 1ns;
    int n_read = 0;
    initial begin
        ADDR = 4'h0;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        FIFO_READ = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic fifo_rd(input int n);
        repeat (n) begin
            @(posedge MCLK);
            FIFO_READ <= 1'b1;
            @(posedge MCLK);
            FIFO_READ <= 1'b0;
            n_read++;
        end
    endtask
endmodule // dtsl_host

// ==== verif/dtsl_top_sva.sv ====
// checker: register port and run relations of the trigger and status logic
module dtsl_top_sva
    import dtsl_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic SECURE,
    // run side
    input wire logic FIFO_WR_EN,
    input wire logic FIFO_CLEAR,
    input wire logic BRK_REQ,
    input wire logic ARMED
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_ctrl_wr;
        WR && ADDR == OFF_CTRL;
    endsequence
    sequence s_rd(logic [3:0] a);
        RD && ADDR == a;
    endsequence
    property p_trig_rsv;
        s_rd(OFF_TRIG) |=> RDATA[5:4] == 2'b00;
    endproperty
    a_trig_rsv: assert property (p_trig_rsv) else $error("trigger spare bits not zero");
    property p_arm_set;
        s_ctrl_wr ##0 (WDATA[7:6] == 2'b11 && !SECURE) |=> ARMED;
    endproperty
    a_arm_set: assert property (p_arm_set) else $error("arm write did not arm");
    property p_arm_stop;
        s_ctrl_wr ##0 !WDATA[CTRL_ARM_BIT] |=> !ARMED;
    endproperty
    a_arm_stop: assert property (p_arm_stop) else $error("arm clear did not stop");
    property p_en_stop;
        s_ctrl_wr ##0 !WDATA[CTRL_EN_BIT] |=> !ARMED;
    endproperty
    a_en_stop: assert property (p_en_stop) else $error("enable clear did not stop");
    property p_mirror;
        s_rd(OFF_STAT) |=> RDATA[STAT_CAPTURE_ACTIVE_FLAG_BIT] == $past(ARMED);
    endproperty
    a_mirror: assert property (p_mirror) else $error("status arm flag differs");
    property p_start_clr;
        $rose(ARMED) |-> $past(FIFO_CLEAR);
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("run began without clear");
    property p_store_run;
        FIFO_WR_EN |-> ARMED;
    endproperty
    a_store_run: assert property (p_store_run) else $error("store outside a run");
    property p_brk_one;
        BRK_REQ |=> !BRK_REQ;
    endproperty
    a_brk_one: assert property (p_brk_one) else $error("break request too long");
endmodule // dtsl_top_sva

bind dtsl_top dtsl_top_sva #(.DEPTH(DEPTH)) u_sva (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SECURE(SECURE), .FIFO_WR_EN(FIFO_WR_EN),
    .FIFO_CLEAR(FIFO_CLEAR), .BRK_REQ(BRK_REQ), .ARMED(ARMED));
